// File: sim/dhc_ctrl_checker.sv
// Checker of the strobe timing driven by the DRAM host controller.
`timescale 1ns/1ps
`default_nettype none

module dhc_ctrl_checker #(
    parameter int PWR_WAIT_CYC = 20,
    parameter int RASP_MAX_CYC = 64
) (
    input wire logic                       clock,
    input wire logic                       rst,
    input wire logic                       req_valid,
    input wire dhc_pkg::dhc_req_type       req,
    input wire logic                       req_ready,
    input wire logic                       rsp_valid,
    input wire logic [dhc_pkg::DATA_W-1:0] rsp_rdata,
    input wire logic                       init_done,
    input wire dhc_pkg::dhc_pins_type      pins,
    input wire logic [dhc_pkg::DATA_W-1:0] dq_in
);
    logic [16:0] lo_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // A page held open too long loses its cells, so the low time is counted.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) lo_r <= 17'h00000;
        else lo_r <= pins.ras_n ? 17'h00000 : lo_r + 17'h00001;
    end

    property p_ras_min; $fell(pins.ras_n) |-> (!pins.ras_n)[*6]; endproperty
    a_ras_min: assert property (p_ras_min) else $error("row pulse short");
    property p_ras_pre; $rose(pins.ras_n) |-> pins.ras_n[*5]; endproperty
    a_ras_pre: assert property (p_ras_pre) else $error("precharge short");
    property p_rasp; lo_r <= RASP_MAX_CYC; endproperty
    a_rasp: assert property (p_rasp) else $error("row held low too long");
    property p_cbr; $fell(pins.ras_n) && !pins.cas_n |-> !$past(pins.cas_n) ##1 (!pins.cas_n)[*2]; endproperty
    a_cbr: assert property (p_cbr) else $error("refresh strobe order");
    property p_cpt;
        $fell(pins.cas_n) && pins.ras_n |-> $past(pins.cas_n, 2) && $past(pins.cas_n, 3) && $past(pins.cas_n, 4);
    endproperty
    a_cpt: assert property (p_cpt) else $error("column precharge short");
    property p_read_we; $fell(pins.cas_n) && !pins.ras_n && pins.we_n |-> pins.we_n[*5] ##1 pins.cas_n; endproperty
    a_read_we: assert property (p_read_we) else $error("write strobe in read");
    property p_early_wr;
        $fell(pins.cas_n) && !pins.ras_n && !pins.we_n |-> !$past(pins.we_n) && pins.dq_oe && $stable(pins.dq_out);
    endproperty
    a_early_wr: assert property (p_early_wr) else $error("write data late");
    property p_col_hold; $fell(pins.cas_n) && !pins.ras_n |-> ($stable(pins.addr))[*5]; endproperty
    a_col_hold: assert property (p_col_hold) else $error("column address moved");
    property p_row_addr; $fell(pins.ras_n) && pins.cas_n |-> ($stable(pins.addr))[*2]; endproperty
    a_row_addr: assert property (p_row_addr) else $error("row address moved");
    property p_take; req_valid && req_ready |=> !req_ready ##[5:19] rsp_valid; endproperty
    a_take: assert property (p_take) else $error("no response");
    property p_init; !init_done |-> pins.cas_n && !req_ready; endproperty
    a_init: assert property (p_init) else $error("access before init");

    c_refresh: cover property ($fell(pins.ras_n) && !pins.cas_n);
    c_page: cover property (req_valid && req_ready ##7 rsp_valid);
    c_write: cover property ($fell(pins.cas_n) && !pins.we_n);
endmodule // dhc_ctrl_checker

bind dhc_ctrl dhc_ctrl_checker #(.PWR_WAIT_CYC(PWR_WAIT_CYC), .RASP_MAX_CYC(RASP_MAX_CYC)) i_chk (
    .clock(clock), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .init_done(init_done), .pins(pins), .dq_in(dq_in));

`default_nettype wire

// File: sim/dhc_dram_model.sv
// Behavioural model of the 256K x 4 asynchronous DRAM on the controller pins.
`timescale 1ns/1ps
`default_nettype none

module dhc_dram_model #(
    // Strobe access time; the column address leads the strobe by a cycle, so its path ends no later.
    parameter int T_ACC_NS = 20,
    parameter int T_OFF_NS = 5
) (
    input  wire dhc_pkg::dhc_pins_type      pins,
    output var  logic [dhc_pkg::DATA_W-1:0] dq
);
    logic [3:0] mem [0:262143];
    logic [8:0] row;
    logic [8:0] col;
    logic [8:0] rcnt = 9'h000;
    logic [3:0] q    = 4'h0;
    logic       column_first_refresh  = 1'b0;
    logic       drv  = 1'b0;

    always @(negedge pins.ras_n) begin
        column_first_refresh = !pins.cas_n;
        if (column_first_refresh) rcnt = rcnt + 9'h001;
        else row = pins.addr;
    end

    always @(negedge pins.cas_n) begin
        if (!pins.ras_n && !column_first_refresh) begin
            col = pins.addr;
            if (!pins.we_n) mem[{row, col}] = pins.dq_out;
            else if (!pins.oe_n) #T_ACC_NS {drv, q} = {1'b1, mem[{row, col}]};
        end
    end

    always @(negedge pins.we_n) if (!pins.cas_n && !pins.ras_n && !column_first_refresh) mem[{row, col}] = pins.dq_out;

    always @(posedge pins.cas_n) #T_OFF_NS drv = 1'b0;

    // Released pins show the inverse of the last word, so a late sample cannot match by luck.
    assign dq = drv ? q : ~q;
endmodule // dhc_dram_model

`default_nettype wire

// File: sim/tb_dhc_ctrl.sv
// Self-checking bench of the DRAM host controller against the DRAM model.
`timescale 1ns/1ps
`default_nettype none

module tb_dhc_ctrl;
    logic                  clock     = 1'b0;
    logic                  rst       = 1'b1;
    logic                  req_valid = 1'b0;
    dhc_pkg::dhc_req_type  req       = '0;
    logic                  req_ready;
    logic                  rsp_valid;
    logic [3:0]            rsp_rdata;
    logic                  init_done;
    dhc_pkg::dhc_pins_type pins;
    logic [3:0]            dq_mem;
    logic [3:0]            dq_in;
    logic [3:0]            exp_q[$];
    logic [3:0]            exp_mem[logic [17:0]];
    logic [15:0]           s;
    logic [17:0]           a         = 18'h00000;
    logic [7:0]            n_init    = 8'h00;
    int                    err_total = 0;
    int                    tests_run = 0;
    int                    cyc       = 0;

    initial begin
        forever #5 clock = ~clock;
    end

    assign dq_in = pins.dq_oe ? pins.dq_out : dq_mem;

    dhc_ctrl #(.PWR_WAIT_CYC(20), .RASP_MAX_CYC(64)) i_dut (
        .clock(clock), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .init_done(init_done), .pins(pins), .dq_in(dq_in));

    dhc_dram_model i_mem (.pins(pins), .dq(dq_mem));

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic chk_data(input logic [3:0] got, input logic [3:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: count %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("Checks %0d, errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // The request is held until a falling edge sees ready, so the next rising edge takes it.
    task automatic do_req(input logic w, input logic [17:0] ad, input logic [3:0] d);
        @(negedge clock);
        req_valid <= 1'b1;
        req <= '{write: w, addr: ad, wdata: d};
        while (req_ready !== 1'b1) @(negedge clock);
        exp_q.push_back(w ? 4'h0 : exp_mem[ad]);
        @(negedge clock);
        req_valid <= 1'b0;
    endtask

    always @(negedge clock) begin
        if (rsp_valid === 1'b1) chk_data(rsp_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 4'hx);
    end

    always @(negedge pins.ras_n or posedge rst) begin
        if (rst) n_init <= 8'h00;
        else if (init_done !== 1'b1) n_init <= n_init + 8'h01;
    end

    always @(posedge clock) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            summarize();
        end
    end

    initial begin
        s = 16'h0016;
        repeat (4) @(negedge clock);
        rst <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 150; i++) begin
                s = lfsr(s);
                a = {s[12] ? a[17:9] : {{6{s[3]}}, s[2:0]}, s[15], s[11:4]};
                if (!exp_mem.exists(a) || (p == 0 && s[14])) begin
                    exp_mem[a] = s[15:12] ^ s[3:0];
                    do_req(1'b1, a, exp_mem[a]);
                end else begin
                    do_req(1'b0, a, s[3:0]);
                end
                if (i == 0) chk_cnt(n_init, 8'h08);
                if (i == 0) chk_cnt({7'h00, init_done}, 8'h01);
                if (s[13]) repeat (s[9:4]) @(negedge clock);
            end
            while (exp_q.size() != 0) @(negedge clock);
            rst <= 1'b1;
            repeat (4) @(negedge clock);
            rst <= 1'b0;
        end
        summarize();
    end
endmodule // tb_dhc_ctrl

`default_nettype wire

// File: src/dhc_ctrl.sv
// Host-side controller that drives a 256K x 4 asynchronous DRAM through its strobes.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Open row serves further columns without reopening.
// - Row strobe falls at least 110 ns apart.
// - Page column cycles at least 40 ns apart.
// - Row strobe low 60 ns to 100K ns.
// - Column strobe leads 5 ns, holds 15 ns.
// - Column strobe high 40 ns before refresh.
// - Reads keep write strobe high throughout.
// - Write data valid at later falling strobe.
// - Wait 200 us, then eight row pulses.
// - Long idle needs eight init cycles again; the code runs init only after reset and relies on refresh never pausing.
// - Write strobe low 20 ns before row rises.
// - Column address held 50 ns after row falls.
// - All 512 rows refreshed every 8 ms.
// - Address split into row then column.
module dhc_ctrl #(
    parameter int PWR_WAIT_CYC = dhc_pkg::PWR_CYC,
    parameter int RASP_MAX_CYC = dhc_pkg::RASP_CYC
) (
    input  wire logic                          clock,
    input  wire logic                          rst,
    input  wire logic                          req_valid,
    input  wire dhc_pkg::dhc_req_type          req,
    output var  logic                          req_ready,
    output var  logic                          rsp_valid,
    output var  logic [dhc_pkg::DATA_W-1:0]    rsp_rdata,
    output var  logic                          init_done,
    output var  dhc_pkg::dhc_pins_type         pins,
    input  wire logic [dhc_pkg::DATA_W-1:0]    dq_in
);

    typedef enum logic [3:0] {
        ST_START, ST_PWR_WAIT, ST_INIT_RAS, ST_INIT_PRE, ST_IDLE, ST_ROW_SET, ST_RAS_WAIT,
        ST_COL, ST_CAS_LOW, ST_OPEN, ST_PRE, ST_REF_CAS, ST_REF_RAS
    } dhc_st_type;

    typedef struct packed {
        dhc_st_type                    state;
        dhc_pkg::dhc_pins_type         pins;
        dhc_pkg::dhc_req_type          cur;
        logic                          pend;
        logic                          req_ready;
        logic                          rsp_valid;
        logic [dhc_pkg::DATA_W-1:0]    rsp_rdata;
        logic                          init_done;
        logic [3:0]                    init_cnt;
        logic [dhc_pkg::REF_W-1:0]     ref_cnt;
        logic                          ref_pend;
        logic [dhc_pkg::AGE_W-1:0]     ras_age;
        logic [dhc_pkg::DATA_W-1:0]    dq_s1;
        logic [dhc_pkg::DATA_W-1:0]    dq_s2;
    } dhc_state_type;

    localparam logic [dhc_pkg::AGE_W-1:0] AGE_LIMIT = dhc_pkg::AGE_W'(RASP_MAX_CYC - dhc_pkg::PAGE_MARGIN);

    dhc_state_type                s_r;
    dhc_state_type                s_nxt;
    logic                         t_load;
    logic [dhc_pkg::TMR_W-1:0]    t_val;
    logic                         t_done;
    logic                         taken;

    function automatic logic [dhc_pkg::TMR_W-1:0] cyc(input int n);
        return dhc_pkg::TMR_W'(n - 1);
    endfunction

    function automatic logic [dhc_pkg::ROW_W-1:0] row_of(input dhc_pkg::dhc_req_type r);
        return r.addr[dhc_pkg::ADDR_W-1:dhc_pkg::COL_W];
    endfunction

    // Puts the column address, write strobe and write data out one cycle ahead of the column strobe.
    function automatic dhc_pkg::dhc_pins_type col_pins(input dhc_pkg::dhc_pins_type p,
                                                       input dhc_pkg::dhc_req_type r);
        dhc_pkg::dhc_pins_type q;
        q        = p;
        q.addr   = r.addr[dhc_pkg::COL_W-1:0];
        q.we_n   = ~r.write;
        q.oe_n   = r.write;
        q.dq_out = r.wdata;
        q.dq_oe  = r.write;
        return q;
    endfunction

    dhc_timer #(
        .WIDTH    (dhc_pkg::TMR_W)
    ) u_timer (
        .clock    (clock),
        .rst      (rst),
        .load     (t_load),
        .load_val (t_val),
        .expired  (t_done)
    );

    assign taken = req_valid && s_r.req_ready;

    always_comb begin
        s_nxt           = s_r;
        t_load          = 1'b0;
        t_val           = '0;
        s_nxt.rsp_valid = 1'b0;
        s_nxt.dq_s1     = dq_in;
        s_nxt.dq_s2     = s_r.dq_s1;

        // The refresh counter runs at all times, so after init the array never sits without strobes.
        if (s_r.ref_cnt == '0) begin
            s_nxt.ref_cnt  = dhc_pkg::REF_W'(dhc_pkg::REF_INT_CYC - 1);
            s_nxt.ref_pend = 1'b1;
        end else begin
            s_nxt.ref_cnt = s_r.ref_cnt - 1'b1;
        end

        if (!s_r.pins.ras_n && s_r.ras_age != '1) begin
            s_nxt.ras_age = s_r.ras_age + 1'b1;
        end else if (s_r.pins.ras_n) begin
            s_nxt.ras_age = '0;
        end

        unique case (s_r.state)
            ST_START: begin
                t_load      = 1'b1;
                t_val       = cyc(PWR_WAIT_CYC);
                s_nxt.state = ST_PWR_WAIT;
            end
            ST_PWR_WAIT: begin
                if (t_done) begin
                    s_nxt.pins.addr  = {5'h00, s_r.init_cnt};
                    s_nxt.pins.ras_n = 1'b0;
                    t_load           = 1'b1;
                    t_val            = cyc(dhc_pkg::RAS_MIN_CYC);
                    s_nxt.state      = ST_INIT_RAS;
                end
            end
            ST_INIT_RAS: begin
                if (t_done) begin
                    // The next row settles during precharge, never on the falling row strobe.
                    s_nxt.pins.ras_n = 1'b1;
                    s_nxt.pins.addr  = {5'h00, s_r.init_cnt + 4'h1};
                    s_nxt.init_cnt   = s_r.init_cnt + 1'b1;
                    t_load           = 1'b1;
                    t_val            = cyc(dhc_pkg::PRE_CYC);
                    s_nxt.state      = ST_INIT_PRE;
                end
            end
            ST_INIT_PRE: begin
                if (t_done) begin
                    if (s_r.init_cnt == 4'(dhc_pkg::INIT_CYCLES)) begin
                        s_nxt.init_done = 1'b1;
                        s_nxt.state     = ST_IDLE;
                    end else begin
                        s_nxt.pins.addr  = {5'h00, s_r.init_cnt};
                        s_nxt.pins.ras_n = 1'b0;
                        t_load           = 1'b1;
                        t_val            = cyc(dhc_pkg::RAS_MIN_CYC);
                        s_nxt.state      = ST_INIT_RAS;
                    end
                end
            end
            ST_IDLE: begin
                // The preceding precharge kept the column strobe high long enough for a counter test too.
                if (s_r.ref_pend) begin
                    s_nxt.pins.cas_n = 1'b0;
                    t_load           = 1'b1;
                    t_val            = cyc(dhc_pkg::CSR_CYC);
                    s_nxt.state      = ST_REF_CAS;
                end else if (taken) begin
                    s_nxt.cur       = req;
                    s_nxt.pins.addr = row_of(req);
                    s_nxt.state     = ST_ROW_SET;
                end
            end
            ST_ROW_SET: begin
                s_nxt.pins.ras_n = 1'b0;
                t_load           = 1'b1;
                t_val            = cyc(dhc_pkg::RCD_CYC);
                s_nxt.state      = ST_RAS_WAIT;
            end
            ST_RAS_WAIT: begin
                if (t_done) begin
                    s_nxt.pins  = col_pins(s_r.pins, s_r.cur);
                    s_nxt.state = ST_COL;
                end
            end
            ST_COL: begin
                s_nxt.pins.cas_n = 1'b0;
                t_load           = 1'b1;
                t_val            = cyc(dhc_pkg::CAS_LOW_CYC);
                s_nxt.state      = ST_CAS_LOW;
            end
            ST_CAS_LOW: begin
                // Address and write strobe stay put until the column strobe rises, well past row fall.
                if (t_done) begin
                    s_nxt.pins.cas_n  = 1'b1;
                    s_nxt.pins.we_n   = 1'b1;
                    s_nxt.pins.oe_n   = 1'b1;
                    s_nxt.pins.dq_oe  = 1'b0;
                    s_nxt.rsp_valid   = 1'b1;
                    s_nxt.rsp_rdata   = s_r.cur.write ? '0 : s_r.dq_s2;
                    s_nxt.state       = ST_OPEN;
                end
            end
            ST_OPEN: begin
                if (taken) begin
                    s_nxt.cur = req;
                    if (row_of(req) == row_of(s_r.cur) && !s_r.ref_pend && s_r.ras_age < AGE_LIMIT) begin
                        s_nxt.pins  = col_pins(s_r.pins, req);
                        s_nxt.state = ST_COL;
                    end else begin
                        s_nxt.pend       = 1'b1;
                        s_nxt.pins.ras_n = 1'b1;
                        t_load           = 1'b1;
                        t_val            = cyc(dhc_pkg::PRE_CYC);
                        s_nxt.state      = ST_PRE;
                    end
                end else if (s_r.ref_pend || s_r.ras_age >= AGE_LIMIT) begin
                    s_nxt.pins.ras_n = 1'b1;
                    t_load           = 1'b1;
                    t_val            = cyc(dhc_pkg::PRE_CYC);
                    s_nxt.state      = ST_PRE;
                end
            end
            ST_PRE: begin
                if (t_done) begin
                    if (s_r.pend) begin
                        s_nxt.pend      = 1'b0;
                        s_nxt.pins.addr = row_of(s_r.cur);
                        s_nxt.state     = ST_ROW_SET;
                    end else begin
                        s_nxt.state = ST_IDLE;
                    end
                end
            end
            ST_REF_CAS: begin
                if (t_done) begin
                    s_nxt.pins.ras_n = 1'b0;
                    s_nxt.ref_pend   = 1'b0;
                    t_load           = 1'b1;
                    t_val            = cyc(dhc_pkg::REF_RAS_CYC);
                    s_nxt.state      = ST_REF_RAS;
                end
            end
            ST_REF_RAS: begin
                if (t_done) begin
                    s_nxt.pins.ras_n = 1'b1;
                    s_nxt.pins.cas_n = 1'b1;
                    t_load           = 1'b1;
                    t_val            = cyc(dhc_pkg::PRE_CYC);
                    s_nxt.state      = ST_PRE;
                end
            end
            default: begin
                s_nxt.state = ST_START;
            end
        endcase

        // A refresh tick in the clearing cycle survives.
        if (s_r.ref_cnt == '0) begin
            s_nxt.ref_pend = 1'b1;
        end

        s_nxt.req_ready = s_nxt.init_done && !s_nxt.ref_pend && !s_nxt.pend
                          && (s_nxt.state == ST_IDLE || s_nxt.state == ST_OPEN) && !taken;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_r       <= '0;
            s_r.state <= ST_START;
            s_r.pins  <= dhc_pkg::PINS_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign req_ready = s_r.req_ready;
    assign rsp_valid = s_r.rsp_valid;
    assign rsp_rdata = s_r.rsp_rdata;
    assign init_done = s_r.init_done;
    assign pins      = s_r.pins;

endmodule // dhc_ctrl

`default_nettype wire

// File: src/dhc_pkg.sv
// Package with timing, sizes and carrier types of the DRAM host controller.
`default_nettype none

package dhc_pkg;

    localparam int CLK_NS       = 10;
    localparam int ROW_W        = 9;
    localparam int COL_W        = 9;
    localparam int ADDR_W       = ROW_W + COL_W;
    localparam int DATA_W       = 4;
    localparam int SYNC_STAGES  = 2;
    localparam int TMR_W        = 15;

    // Least times, in ns, fastest grade.
    localparam int T_RC_NS      = 110;
    localparam int T_RAS_NS     = 60;
    localparam int T_RP_NS      = 40;
    localparam int T_RCD_NS     = 15;
    localparam int T_AA_NS      = 30;
    localparam int T_CSR_NS     = 5;
    localparam int T_CHR_NS     = 15;
    localparam int T_CPT_NS     = 40;
    localparam int T_PC_NS      = 40;
    // Longest times, in ns.
    localparam int T_RASP_NS    = 100000;
    localparam int T_REF_ROW_NS = 8000000 / 512;
    // Power-up pause, in ns.
    localparam int T_PWR_NS     = 200000;

    localparam int RC_CYC       = (T_RC_NS + CLK_NS - 1) / CLK_NS;
    localparam int RAS_MIN_CYC  = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
    localparam int RP_CYC       = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RCD_CYC      = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
    localparam int AA_CYC       = (T_AA_NS + CLK_NS - 1) / CLK_NS;
    localparam int CSR_CYC      = (T_CSR_NS + CLK_NS - 1) / CLK_NS;
    localparam int CHR_CYC      = (T_CHR_NS + CLK_NS - 1) / CLK_NS;
    localparam int CPT_CYC      = (T_CPT_NS + CLK_NS - 1) / CLK_NS;
    localparam int PC_CYC       = (T_PC_NS + CLK_NS - 1) / CLK_NS;
    localparam int RASP_CYC     = T_RASP_NS / CLK_NS;
    localparam int REF_INT_CYC  = T_REF_ROW_NS / CLK_NS;
    localparam int PWR_CYC      = (T_PWR_NS + CLK_NS - 1) / CLK_NS;

    // Precharge is stretched so that row strobe low plus high meets the cycle time.
    localparam int PRE_CYC      = (RC_CYC - RAS_MIN_CYC > RP_CYC) ? RC_CYC - RAS_MIN_CYC : RP_CYC;
    // Column strobe stays low until read data have crossed the input synchroniser.
    localparam int CAS_LOW_CYC  = AA_CYC + SYNC_STAGES;
    // Refresh keeps the column strobe low for the whole row pulse.
    localparam int REF_RAS_CYC  = (RAS_MIN_CYC > CHR_CYC) ? RAS_MIN_CYC : CHR_CYC;
    localparam int INIT_CYCLES  = 8;
    localparam int PAGE_MARGIN  = 32;
    localparam int AGE_W        = 14;
    localparam int REF_W        = 11;

    localparam logic [TMR_W-1:0] TMR_RST = 15'h0000;

    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dhc_req_type;

    typedef struct packed {
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic              oe_n;
        logic [ROW_W-1:0]  addr;
        logic [DATA_W-1:0] dq_out;
        logic              dq_oe;
    } dhc_pins_type;

    localparam dhc_pins_type PINS_IDLE = '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                                           addr: 9'h000, dq_out: 4'h0, dq_oe: 1'b0};

endpackage

`default_nettype wire

// File: src/dhc_timer.sv
// Down-counting delay timer with a registered expiry flag.
`timescale 1ns/1ps
`default_nettype none

module dhc_timer #(
    parameter int WIDTH = 15
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_val,
    output var  logic             expired
);

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             expired;
    } dhc_tmr_state_type;

    dhc_tmr_state_type s_r;
    dhc_tmr_state_type s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (load) begin
            s_nxt.cnt = load_val;
        end else if (s_r.cnt != '0) begin
            s_nxt.cnt = s_r.cnt - 1'b1;
        end
        s_nxt.expired = (s_nxt.cnt == '0);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign expired = s_r.expired;

endmodule // dhc_timer

`default_nettype wire
